// File: ept_pwm_timer.sv
// Eight-channel PWM timer with AXI4-Lite register slave and eight output pins.
// Assumes one 125 MHz clock, synchronous active-low reset, pins driven straight from flops.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`include "ept_consts.svh"

// Functional notes
// - Eight channels, each with its own 8-bit counter and its own software period and duty.
// - Each channel runs on its own and its duty reaches from never active to always active.
// - A channel can run in PCM mode instead of plain pulse-width modulation.
// - Software picks the active level of each output, inverting the waveform.
// - Each channel is either left aligned to the period start or centred in the period.
// - Pairs 7/6, 5/4, 3/2 and 1/0 can each be joined into one 16-bit channel.
module ept_pwm_timer #(
	parameter int CHANNELS = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire ept_pkg::ept_axi_req_t s_axi_req,
	output ept_pkg::ept_axi_rsp_t s_axi_rsp,
	output logic [7:0] pwm_out
);

	ept_pkg::ept_state_t s_reg;
	ept_pkg::ept_state_t s_next;

	// Packed state and register map are laid out for exactly eight channels
	if (CHANNELS != 8) begin : param_check_g
		$error("Only eight channels are supported");
	end

	// One cycle of one channel, 8-bit values arrive zero-extended
	function automatic ept_pkg::ept_step_t chan_step(input logic en, input logic cen, input logic pcm,
			input logic dir, input logic [15:0] p, input logic [15:0] d, input logic [15:0] c);
		logic [16:0] sum;
		logic [16:0] inc;
		ept_pkg::ept_step_t r;
		sum = {1'b0, c} + {1'b0, d};
		inc = {1'b0, c} + 17'h00001;
		r.cnt = c;
		r.dir = dir;
		r.act = 1'b0;
		if (!en) begin
			r.cnt = 16'h0000;
			r.dir = 1'b0;
		end else if (pcm) begin
			// First-order noise shaping: density of active cycles is duty over period
			if (d == 16'h0000) begin
				r.cnt = 16'h0000;
			end else if (d >= p) begin
				r.cnt = 16'h0000;
				r.act = 1'b1;
			end else if (sum >= {1'b0, p}) begin
				r.cnt = 16'(sum - {1'b0, p});
				r.act = 1'b1;
			end else begin
				r.cnt = sum[15:0];
			end
		end else begin
			if (d == 16'h0000) begin
				r.act = 1'b0;
			end else if (d >= p) begin
				r.act = 1'b1;
			end else if (cen) begin
				r.act = sum > {1'b0, p};
			end else begin
				r.act = c < d;
			end
			if (!cen) begin
				r.cnt = (inc >= {1'b0, p}) ? 16'h0000 : inc[15:0];
				r.dir = 1'b0;
			end else if (!dir) begin
				if (c >= p) begin
					r.dir = 1'b1;
					r.cnt = (c == 16'h0000) ? 16'h0000 : 16'(c - 16'h0001);
				end else begin
					r.cnt = inc[15:0];
				end
			end else begin
				if (c == 16'h0000) begin
					r.dir = 1'b0;
					r.cnt = (p == 16'h0000) ? 16'h0000 : 16'h0001;
				end else begin
					r.cnt = 16'(c - 16'h0001);
				end
			end
		end
		return r;
	endfunction

	always_comb begin
		ept_pkg::ept_step_t st;
		ept_pkg::ept_step_t sh;
		logic [7:0] act;
		logic [7:0] wa;
		logic [7:0] ra;
		logic wok;
		logic rok;
		logic [31:0] rd;
		int lo;
		int hi;
		st = '0;
		sh = '0;
		act = 8'h00;
		wa = s_reg.awaddr[7:0];
		ra = s_axi_req.araddr[7:0];
		wok = 1'b0;
		rok = 1'b0;
		rd = 32'h00000000;
		lo = 0;
		hi = 0;
		s_next = s_reg;

		for (int p = 0; p < CHANNELS / 2; p++) begin
			lo = 2 * p;
			hi = 2 * p + 1;
			if (s_reg.cat[p]) begin
				// Joined pair: high channel holds the upper byte and owns the pin
				sh = chan_step(s_reg.en[hi], s_reg.cen[hi], s_reg.pcm[hi], s_reg.dir[hi],
					{s_reg.per[hi], s_reg.per[lo]}, {s_reg.duty[hi], s_reg.duty[lo]},
					{s_reg.cnt[hi], s_reg.cnt[lo]});
				s_next.cnt[hi] = sh.cnt[15:8];
				s_next.cnt[lo] = sh.cnt[7:0];
				s_next.dir[hi] = sh.dir;
				s_next.dir[lo] = 1'b0;
				act[hi] = sh.act;
				act[lo] = 1'b0;
			end else begin
				st = chan_step(s_reg.en[lo], s_reg.cen[lo], s_reg.pcm[lo], s_reg.dir[lo],
					{8'h00, s_reg.per[lo]}, {8'h00, s_reg.duty[lo]}, {8'h00, s_reg.cnt[lo]});
				s_next.cnt[lo] = st.cnt[7:0];
				s_next.dir[lo] = st.dir;
				act[lo] = st.act;
				sh = chan_step(s_reg.en[hi], s_reg.cen[hi], s_reg.pcm[hi], s_reg.dir[hi],
					{8'h00, s_reg.per[hi]}, {8'h00, s_reg.duty[hi]}, {8'h00, s_reg.cnt[hi]});
				s_next.cnt[hi] = sh.cnt[7:0];
				s_next.dir[hi] = sh.dir;
				act[hi] = sh.act;
			end
		end
		s_next.out = ~(act ^ s_reg.pol);

		// Write address and data are taken independently, then committed together
		if (s_axi_req.awvalid && !s_reg.aw_got && !s_reg.bvalid) begin
			s_next.aw_got = 1'b1;
			s_next.awaddr = s_axi_req.awaddr;
		end
		if (s_axi_req.wvalid && !s_reg.w_got && !s_reg.bvalid) begin
			s_next.w_got = 1'b1;
			s_next.wdata = s_axi_req.wdata;
			s_next.wstrb = s_axi_req.wstrb;
		end
		if (s_reg.aw_got && s_reg.w_got) begin
			wok = (s_reg.awaddr[31:7] == 25'h0000000) && (wa[1:0] == 2'b00);
			if (wok) begin
				unique case (wa[6:5])
					`EPT_REGION_CTRL: begin
						wok = (wa[4:0] <= `EPT_PCM_OFF);
						if (s_reg.wstrb[0]) begin
							if (wa == `EPT_ENABLE_OFF) s_next.en = s_reg.wdata[7:0];
							if (wa == `EPT_POL_OFF) s_next.pol = s_reg.wdata[7:0];
							if (wa == `EPT_ALIGN_OFF) s_next.cen = s_reg.wdata[7:0];
							if (wa == `EPT_CAT_OFF) s_next.cat = s_reg.wdata[3:0];
							if (wa == `EPT_PCM_OFF) s_next.pcm = s_reg.wdata[7:0];
						end
					end
					`EPT_REGION_PER: if (s_reg.wstrb[0]) s_next.per[wa[4:2]] = s_reg.wdata[7:0];
					`EPT_REGION_DUTY: if (s_reg.wstrb[0]) s_next.duty[wa[4:2]] = s_reg.wdata[7:0];
					`EPT_REGION_CNT: wok = 1'b0;
				endcase
			end
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = wok ? `EPT_RESP_OKAY : `EPT_RESP_SLVERR;
		end
		if (s_reg.bvalid && s_axi_req.bready) begin
			s_next.bvalid = 1'b0;
		end

		if (s_reg.rvalid && s_axi_req.rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_req.arvalid && !s_reg.rvalid) begin
			rok = (s_axi_req.araddr[31:7] == 25'h0000000) && (ra[1:0] == 2'b00);
			unique case (ra[6:5])
				`EPT_REGION_CTRL: begin
					rok = rok && (ra[4:0] <= `EPT_PCM_OFF);
					if (ra == `EPT_ENABLE_OFF) rd = {24'h000000, s_reg.en};
					if (ra == `EPT_POL_OFF) rd = {24'h000000, s_reg.pol};
					if (ra == `EPT_ALIGN_OFF) rd = {24'h000000, s_reg.cen};
					if (ra == `EPT_CAT_OFF) rd = {28'h0000000, s_reg.cat};
					if (ra == `EPT_PCM_OFF) rd = {24'h000000, s_reg.pcm};
				end
				`EPT_REGION_PER: rd = {24'h000000, s_reg.per[ra[4:2]]};
				`EPT_REGION_DUTY: rd = {24'h000000, s_reg.duty[ra[4:2]]};
				`EPT_REGION_CNT: rd = {24'h000000, s_reg.cnt[ra[4:2]]};
			endcase
			s_next.rvalid = 1'b1;
			s_next.rdata = rok ? rd : 32'h00000000;
			s_next.rresp = rok ? `EPT_RESP_OKAY : `EPT_RESP_SLVERR;
		end

		if (!aresetn) begin
			s_next = '0;
			s_next.pol = `EPT_POL_RST;
		end
	end

	always_ff @(posedge aclk) begin
		s_reg <= s_next;
	end

	assign pwm_out = s_reg.out;
	assign s_axi_rsp.awready = !s_reg.aw_got && !s_reg.bvalid;
	assign s_axi_rsp.wready = !s_reg.w_got && !s_reg.bvalid;
	assign s_axi_rsp.bvalid = s_reg.bvalid;
	assign s_axi_rsp.bresp = s_reg.bresp;
	assign s_axi_rsp.arready = !s_reg.rvalid;
	assign s_axi_rsp.rvalid = s_reg.rvalid;
	assign s_axi_rsp.rdata = s_reg.rdata;
	assign s_axi_rsp.rresp = s_reg.rresp;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic plain0;
	logic plain2;
	assign plain0 = s_reg.en[0] && !s_reg.pcm[0] && !s_reg.cat[0];
	assign plain2 = s_reg.en[2] && !s_reg.pcm[2] && !s_reg.cen[2] && !s_reg.cat[1];

	idle_counter_a: assert property (!s_reg.en[5] && !s_reg.cat[2] |=> s_reg.cnt[5] == 8'h00)
		else $error("Disabled channel counter not cleared");
	left_count_a: assert property (plain2 && s_reg.cnt[2] < s_reg.per[2] - 8'h01 && s_reg.per[2] != 8'h00
			|=> s_reg.cnt[2] == $past(s_reg.cnt[2]) + 8'h01)
		else $error("Left aligned counter did not step");
	zero_duty_a: assert property (plain0 && s_reg.duty[0] == 8'h00 |=> pwm_out[0] == !$past(s_reg.pol[0]))
		else $error("Zero duty output went active");
	full_duty_a: assert property (plain0 && s_reg.duty[0] != 8'h00 && s_reg.duty[0] >= s_reg.per[0]
			|=> pwm_out[0] == $past(s_reg.pol[0]))
		else $error("Full duty output not active");
	pol_invert_a: assert property (!s_reg.en[1] && !s_reg.cat[0] |=> pwm_out[1] == !$past(s_reg.pol[1]))
		else $error("Idle output level not inverse of polarity");
	centre_turn_a: assert property (s_reg.en[3] && s_reg.cen[3] && !s_reg.pcm[3] && !s_reg.cat[1] && !s_reg.dir[3]
			&& s_reg.cnt[3] == s_reg.per[3] && s_reg.per[3] != 8'h00
			|=> s_reg.dir[3] && s_reg.cnt[3] == $past(s_reg.per[3]) - 8'h01)
		else $error("Centred counter did not turn at period");
	pair_low_a: assert property (s_reg.cat[0] |=> pwm_out[0] == !$past(s_reg.pol[0]))
		else $error("Low half of joined pair drove active");
	pair_count_a: assert property (s_reg.cat[0] && s_reg.en[1] && !s_reg.cen[1] && !s_reg.pcm[1]
			&& {s_reg.cnt[1], s_reg.cnt[0]} == 16'h00ff && {s_reg.per[1], s_reg.per[0]} > 16'h0100
			|=> s_reg.cnt[1] == 8'h01 && s_reg.cnt[0] == 8'h00)
		else $error("Joined pair counter did not carry");
	pcm_full_a: assert property (s_reg.en[4] && s_reg.pcm[4] && !s_reg.cat[2] && s_reg.duty[4] != 8'h00
			&& s_reg.duty[4] >= s_reg.per[4] |=> pwm_out[4] == $past(s_reg.pol[4]))
		else $error("PCM full duty not active");

	centre_run_c: cover property (s_reg.cen[3] && s_reg.en[3] && s_reg.dir[3] ##1 !s_reg.dir[3]);
	pair_pulse_c: cover property (s_reg.cat[0] && s_reg.en[1] ##1 $rose(pwm_out[1]));
	pcm_toggle_c: cover property (s_reg.pcm[4] && s_reg.en[4] ##1 $changed(pwm_out[4]));
	bus_write_c: cover property (s_reg.bvalid && s_axi_req.bready);

endmodule // ept_pwm_timer

// File: ept_consts.svh
// Register offsets, reset values and bus codes of the eight-channel PWM timer.
// Assumes byte addressing on a 32-bit AXI4-Lite slave port.
`ifndef EPT_CONSTS_SVH
`define EPT_CONSTS_SVH
`define EPT_ENABLE_OFF 8'h00
`define EPT_POL_OFF 8'h04
`define EPT_ALIGN_OFF 8'h08
`define EPT_CAT_OFF 8'h0c
`define EPT_PCM_OFF 8'h10
`define EPT_PER_OFF 8'h20
`define EPT_DUTY_OFF 8'h40
`define EPT_CNT_OFF 8'h60
`define EPT_REGION_CTRL 2'h0
`define EPT_REGION_PER 2'h1
`define EPT_REGION_DUTY 2'h2
`define EPT_REGION_CNT 2'h3
`define EPT_POL_RST 8'hff
`define EPT_RESP_OKAY 2'b00
`define EPT_RESP_SLVERR 2'b10
`endif

// File: ept_pkg.sv
// Types of the eight-channel PWM timer: bus carriers, channel step result, module state.
// Assumes ept_consts.svh supplies the numeric constants.
package ept_pkg;
	typedef struct packed {
		logic [31:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [31:0] araddr;
		logic arvalid;
		logic rready;
	} ept_axi_req_t;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ept_axi_rsp_t;
	typedef struct packed {
		logic [15:0] cnt;
		logic dir;
		logic act;
	} ept_step_t;
	typedef struct packed {
		logic [7:0] en;
		logic [7:0] pol;
		logic [7:0] cen;
		logic [7:0] pcm;
		logic [3:0] cat;
		logic [7:0][7:0] per;
		logic [7:0][7:0] duty;
		logic [7:0][7:0] cnt;
		logic [7:0] dir;
		logic [7:0] out;
		logic aw_got;
		logic w_got;
		logic [31:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} ept_state_t;
endpackage

// File: eight_channel_pwm_timer_test.sv
// Self-checking bench for the eight-channel PWM timer: AXI4-Lite register tasks and pin duty counts.
// Assumes ept_pkg is compiled first and ept_consts.svh is on the include path.
`include "ept_consts.svh"
module eight_channel_pwm_timer_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	ept_pkg::ept_axi_req_t req = '0;
	ept_pkg::ept_axi_rsp_t rsp;
	logic [7:0] pwm_out;
	int mismatches = 0;
	int check_count = 0;
	int cnt;
	int rises;
	logic [31:0] rdat;
	logic [1:0] rr;
	int exp_act[4] = '{12, 0, 40, 40};
	int exp_rise[4] = '{4, 0, 0, 0};
	always #4 aclk = ~aclk;
	ept_pwm_timer dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp), .pwm_out(pwm_out));
	task automatic complete_run;
		if (mismatches == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Address and data offered together; each released at its own handshake edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
		int n;
		logic aw_done;
		logic w_done;
		logic got;
		n = 0;
		aw_done = 1'b0;
		w_done = 1'b0;
		got = 1'b0;
		@(posedge aclk);
		req.awaddr <= {24'h0, a};
		req.awvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (!got && n < 200) begin
			@(posedge aclk);
			n++;
			if (!aw_done && rsp.awready === 1'b1) begin
				aw_done = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (!w_done && rsp.wready === 1'b1) begin
				w_done = 1'b1;
				req.wvalid <= 1'b0;
			end
			if (rsp.bvalid === 1'b1) begin
				got = 1'b1;
				req.bready <= 1'b0;
				chk(rsp.bresp, exp_resp);
			end
		end
		if (!got) begin
			mismatches++;
			$display("[ERR] %0t write response missing", $time);
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		logic got;
		n = 0;
		got = 1'b0;
		d = 32'hxxxxxxxx;
		resp = 2'bxx;
		@(posedge aclk);
		req.araddr <= {24'h0, a};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		while (!got && n < 200) begin
			@(posedge aclk);
			n++;
			if (req.arvalid && rsp.arready === 1'b1) begin
				req.arvalid <= 1'b0;
			end
			if (rsp.rvalid === 1'b1) begin
				got = 1'b1;
				d = rsp.rdata;
				resp = rsp.rresp;
				req.rready <= 1'b0;
			end
		end
		if (!got) begin
			mismatches++;
			$display("[ERR] %0t read response missing", $time);
		end
	endtask
	task automatic chan(input int ch, input logic [7:0] per, input logic [7:0] duty);
		wr(8'(`EPT_PER_OFF + 4 * ch), {24'h0, per}, `EPT_RESP_OKAY);
		wr(8'(`EPT_DUTY_OFF + 4 * ch), {24'h0, duty}, `EPT_RESP_OKAY);
	endtask
	// Settling time covers a joined period of up to 512 cycles
	task automatic setup(input logic [7:0] en, input logic [7:0] pol, input logic [7:0] cen,
		input logic [7:0] pcm, input logic [7:0] cat);
		wr(`EPT_ENABLE_OFF, {24'h0, en}, `EPT_RESP_OKAY);
		wr(`EPT_POL_OFF, {24'h0, pol}, `EPT_RESP_OKAY);
		wr(`EPT_ALIGN_OFF, {24'h0, cen}, `EPT_RESP_OKAY);
		wr(`EPT_PCM_OFF, {24'h0, pcm}, `EPT_RESP_OKAY);
		wr(`EPT_CAT_OFF, {24'h0, cat}, `EPT_RESP_OKAY);
		repeat (520) @(posedge aclk);
	endtask
	// Whole periods are measured, so the counts do not depend on the starting phase
	task automatic meas(input int ch, input int n);
		logic prev;
		cnt = 0;
		rises = 0;
		@(posedge aclk);
		prev = pwm_out[ch];
		repeat (n) begin
			@(posedge aclk);
			if (pwm_out[ch] === 1'b1) begin
				cnt++;
				if (prev === 1'b0) begin
					rises++;
				end
			end
			prev = pwm_out[ch];
		end
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		complete_run;
	end
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({24'h0, pwm_out}, 32'h0);
		rd(`EPT_POL_OFF, rdat, rr);
		chk(rdat, {24'h0, `EPT_POL_RST});
		rd(`EPT_ENABLE_OFF, rdat, rr);
		chk(rdat, 32'h0);
		rd(8'h14, rdat, rr);
		chk({30'h0, rr}, {30'h0, `EPT_RESP_SLVERR});
		wr(`EPT_CNT_OFF, 32'h5, `EPT_RESP_SLVERR);
		chan(0, 8'h0a, 8'h03);
		chan(1, 8'h0a, 8'h00);
		chan(2, 8'h0a, 8'h0a);
		chan(3, 8'h0a, 8'hff);
		rd(8'(`EPT_PER_OFF + 8'h04), rdat, rr);
		chk(rdat, 32'h0000000a);
		rd(8'(`EPT_DUTY_OFF + 8'h08), rdat, rr);
		chk(rdat, 32'h0000000a);
		setup(8'h0f, 8'hff, 8'h00, 8'h00, 8'h00);
		for (int ch = 0; ch < 4; ch++) begin
			meas(ch, 40);
			chk(32'(cnt), 32'(exp_act[ch]));
			chk(32'(rises), 32'(exp_rise[ch]));
		end
		rd(`EPT_CNT_OFF, rdat, rr);
		chk({31'h0, rdat < 32'h0000000a}, 32'h1);
		setup(8'h0f, 8'hfe, 8'h00, 8'h00, 8'h00);
		meas(0, 40);
		chk(32'(cnt), 32'h1c);
		setup(8'h01, 8'hff, 8'h01, 8'h00, 8'h00);
		meas(0, 40);
		chk(32'(cnt), 32'h0a);
		setup(8'h01, 8'hff, 8'h00, 8'h01, 8'h00);
		meas(0, 40);
		chk(32'(cnt), 32'h0c);
		chk(32'(rises), 32'h0c);
		chan(3, 8'h01, 8'h00);
		chan(2, 8'h00, 8'h80);
		setup(8'h08, 8'hff, 8'h00, 8'h00, 8'h02);
		meas(3, 512);
		chk(32'(cnt), 32'h100);
		meas(2, 512);
		chk(32'(cnt), 32'h0);
		// Pair 1/0 joined across the byte carry, channel 3 centred, channel 4 PCM at full duty
		chan(0, 8'h00, 8'h00);
		chan(1, 8'h02, 8'h01);
		chan(3, 8'h0a, 8'h03);
		chan(4, 8'h0a, 8'h0a);
		setup(8'h1a, 8'hff, 8'h08, 8'h10, 8'h01);
		meas(1, 512);
		chk(32'(cnt), 32'h100);
		meas(0, 512);
		chk(32'(cnt), 32'h0);
		meas(3, 40);
		chk(32'(cnt), 32'h0a);
		meas(4, 40);
		chk(32'(cnt), 32'h28);
		// Zero and full duty on a plain channel
		chan(0, 8'h0a, 8'h00);
		setup(8'h01, 8'hff, 8'h00, 8'h00, 8'h00);
		meas(0, 40);
		chk(32'(cnt), 32'h0);
		wr(`EPT_DUTY_OFF, 32'h0000000a, `EPT_RESP_OKAY);
		meas(0, 40);
		chk(32'(cnt), 32'h28);
		// Reset in mid-run returns registers and pins to their idle state
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk({24'h0, pwm_out}, 32'h0);
		rd(`EPT_ENABLE_OFF, rdat, rr);
		chk(rdat, 32'h0);
		rd(`EPT_CAT_OFF, rdat, rr);
		chk(rdat, 32'h0);
		complete_run;
	end
endmodule // eight_channel_pwm_timer_test
